// file: logic/gpc_top.sv
// Input side of a 32-line parallel I/O controller and its full register map.
// Assumes synchronous pins, a one-cycle register port and a clock-enable from power management.
// Function
// - Pin level register shows actual pin levels
// - Clock off freezes pin level register
// - Filter rejects no glitch caught at a sample edge, passes full cycles
// - Filter adds one cycle latency
// - Filter enable/disable writes set/clear filter status
// - Filter feeds only pin level and detector
// - Filters sample only while clock enabled
// - Change enable/disable writes set/clear mask
// - Change detected from two successive samples
// - Change detection works in every filter setting, but only while clock enabled
// - Detected change sets its flag bit
// - Interrupt is registered OR of flags ANDed with mask
// - Reading flags clears all flags except changes detected in the read cycle
// - 32-bit registers; unimplemented lines read zero
// - Unmultiplexed lines always show controller ownership
// - Output level direct write changes only lines where direct-write set; set/clear writes reach every line
// - Flags reset zero, capture changes afterwards
// - A select clears, B select sets
// - Pull-up status one means disabled
// - AB status zero selects A, one B
// - Ownership one means controller drives line
// - Direct write updates unmasked bits together
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module gpc_top #(
  parameter logic [31:0] LINE_MASK = 32'hFFFF_FFFF,
  parameter logic [31:0] MUX_MASK = 32'hFFFF_FFFF,
  parameter logic [31:0] OWN_RESET = 32'hFFFF_FFFF
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [gpc_pkg::AW-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [31:0] i_pin,
  output logic [31:0] o_periph_in,
  output gpc_pkg::gpc_pad_cfg_t o_pad_cfg,
  output logic o_irq
);
  gpc_pkg::gpc_bus_req_t req;
  logic [31:0] own_r, drive_r, flt_r, level_r, mask_r, flags_r, od_r, pu_r, pab_r, dw_r;
  logic [31:0] pin_level_r, prev_r, samp_r, filt, change, rdata_nxt;
  logic irq_r;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  function automatic logic hit_wr(input gpc_pkg::gpc_bus_req_t r, input logic [7:0] ofs);
    hit_wr = r.wr && (r.addr == ofs);
  endfunction

  // Set/clear pair; writes to undefined lines dropped
  function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic s, input logic c,
                                          input logic [31:0] d, input logic [31:0] lm);
    logic [31:0] v;
    v = cur;
    if (s) begin
      v = v | (d & lm);
    end
    if (c) begin
      v = v & ~(d & lm);
    end
    set_clr = v & lm;
  endfunction

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // Reset already masked, so ownership never moves without a write
      own_r <= (OWN_RESET & LINE_MASK & MUX_MASK) | (LINE_MASK & ~MUX_MASK);
    end else begin
      own_r <= set_clr(own_r, hit_wr(req, gpc_pkg::OFS_OWN_EN), hit_wr(req, gpc_pkg::OFS_OWN_DIS),
                       i_wdata, LINE_MASK & MUX_MASK) | (LINE_MASK & ~MUX_MASK);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      drive_r <= gpc_pkg::RST_ZERO;
      od_r <= gpc_pkg::RST_ZERO;
      pu_r <= gpc_pkg::RST_ZERO;
      dw_r <= gpc_pkg::RST_ZERO;
    end else begin
      drive_r <= set_clr(drive_r, hit_wr(req, gpc_pkg::OFS_DRV_EN), hit_wr(req, gpc_pkg::OFS_DRV_DIS),
                         i_wdata, LINE_MASK);
      od_r <= set_clr(od_r, hit_wr(req, gpc_pkg::OFS_OD_EN), hit_wr(req, gpc_pkg::OFS_OD_DIS),
                      i_wdata, LINE_MASK);
      pu_r <= set_clr(pu_r, hit_wr(req, gpc_pkg::OFS_PU_DIS), hit_wr(req, gpc_pkg::OFS_PU_EN),
                      i_wdata, LINE_MASK);
      dw_r <= set_clr(dw_r, hit_wr(req, gpc_pkg::OFS_DW_EN), hit_wr(req, gpc_pkg::OFS_DW_DIS),
                      i_wdata, LINE_MASK);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pab_r <= gpc_pkg::RST_ZERO;
    end else begin
      pab_r <= set_clr(pab_r, hit_wr(req, gpc_pkg::OFS_PB_SEL), hit_wr(req, gpc_pkg::OFS_PA_SEL),
                       i_wdata, LINE_MASK);
    end
  end

  // Output level: set/clear, then masked direct write
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      level_r <= gpc_pkg::RST_ZERO;
    end else if (hit_wr(req, gpc_pkg::OFS_OUT_LVL)) begin
      level_r <= ((level_r & ~dw_r) | (i_wdata & dw_r)) & LINE_MASK;
    end else begin
      level_r <= set_clr(level_r, hit_wr(req, gpc_pkg::OFS_LVL_SET), hit_wr(req, gpc_pkg::OFS_LVL_CLR),
                         i_wdata, LINE_MASK);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flt_r <= gpc_pkg::RST_ZERO;
      mask_r <= gpc_pkg::RST_ZERO;
    end else begin
      flt_r <= set_clr(flt_r, hit_wr(req, gpc_pkg::OFS_FLT_EN), hit_wr(req, gpc_pkg::OFS_FLT_DIS),
                       i_wdata, LINE_MASK);
      mask_r <= set_clr(mask_r, hit_wr(req, gpc_pkg::OFS_CHG_EN), hit_wr(req, gpc_pkg::OFS_CHG_DIS),
                        i_wdata, LINE_MASK);
    end
  end

  // Pins are sampled once per enabled clock; with synchronous pins no pulse
  // shorter than a cycle is ever seen, so the filter is one extra sample stage.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      samp_r <= gpc_pkg::RST_ZERO;
    end else if (i_clk_en) begin
      samp_r <= i_pin & LINE_MASK;
    end
  end

  genvar g;
  generate
    for (g = 0; g < gpc_pkg::LINES; g++) begin : g_flt
      // Filtered line lags one cycle; a one-cycle pulse still passes
      assign filt[g] = flt_r[g] ? samp_r[g] : (i_pin[g] & LINE_MASK[g]);
    end
  endgenerate

  // Peripherals see the raw pin, never the filter
  assign o_periph_in = i_pin;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_level_r <= gpc_pkg::RST_ZERO;
      prev_r <= gpc_pkg::RST_ZERO;
    end else if (i_clk_en) begin
      pin_level_r <= filt;
      prev_r <= pin_level_r;
    end
  end

  // Reset state counts as a sample; first live sample may flag a change
  assign change = i_clk_en ? ((filt ^ pin_level_r) & LINE_MASK) : gpc_pkg::RST_ZERO;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flags_r <= gpc_pkg::RST_ZERO;
    end else if (req.rd && req.addr == gpc_pkg::OFS_CHG_FLAGS) begin
      flags_r <= change;
    end else begin
      flags_r <= flags_r | change;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags_r & mask_r);
    end
  end
  assign o_irq = irq_r;

  always_comb begin
    unique case (req.addr)
      gpc_pkg::OFS_OWN_ST: rdata_nxt = own_r;
      gpc_pkg::OFS_DRV_ST: rdata_nxt = drive_r;
      gpc_pkg::OFS_FLT_ST: rdata_nxt = flt_r;
      gpc_pkg::OFS_OUT_LVL: rdata_nxt = level_r;
      gpc_pkg::OFS_PIN_LVL: rdata_nxt = pin_level_r;
      gpc_pkg::OFS_CHG_MASK: rdata_nxt = mask_r;
      gpc_pkg::OFS_CHG_FLAGS: rdata_nxt = flags_r;
      gpc_pkg::OFS_OD_ST: rdata_nxt = od_r;
      gpc_pkg::OFS_PU_ST: rdata_nxt = pu_r;
      gpc_pkg::OFS_PAB_ST: rdata_nxt = pab_r;
      gpc_pkg::OFS_DW_ST: rdata_nxt = dw_r;
      default: rdata_nxt = gpc_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= gpc_pkg::RST_ZERO;
    end else if (req.rd) begin
      o_rdata <= rdata_nxt & LINE_MASK;
    end else begin
      o_rdata <= gpc_pkg::RST_ZERO;
    end
  end

  assign o_pad_cfg = '{own: own_r, drive: drive_r, level: level_r, open_drain: od_r,
                       pullup_off: pu_r, periph_b: pab_r};
endmodule
`default_nettype wire

// file: logic/gpc_pkg.sv
// Package for the parallel I/O input and register block.
// Assumes a 32-bit plain register port with byte offsets.
package gpc_pkg;
  localparam int unsigned LINES = 32;
  localparam int unsigned AW = 8;
  localparam logic [7:0] OFS_OWN_EN = 8'h00;
  localparam logic [7:0] OFS_OWN_DIS = 8'h04;
  localparam logic [7:0] OFS_OWN_ST = 8'h08;
  localparam logic [7:0] OFS_DRV_EN = 8'h10;
  localparam logic [7:0] OFS_DRV_DIS = 8'h14;
  localparam logic [7:0] OFS_DRV_ST = 8'h18;
  localparam logic [7:0] OFS_FLT_EN = 8'h20;
  localparam logic [7:0] OFS_FLT_DIS = 8'h24;
  localparam logic [7:0] OFS_FLT_ST = 8'h28;
  localparam logic [7:0] OFS_LVL_SET = 8'h30;
  localparam logic [7:0] OFS_LVL_CLR = 8'h34;
  localparam logic [7:0] OFS_OUT_LVL = 8'h38;
  localparam logic [7:0] OFS_PIN_LVL = 8'h3C;
  localparam logic [7:0] OFS_CHG_EN = 8'h40;
  localparam logic [7:0] OFS_CHG_DIS = 8'h44;
  localparam logic [7:0] OFS_CHG_MASK = 8'h48;
  localparam logic [7:0] OFS_CHG_FLAGS = 8'h4C;
  localparam logic [7:0] OFS_OD_EN = 8'h50;
  localparam logic [7:0] OFS_OD_DIS = 8'h54;
  localparam logic [7:0] OFS_OD_ST = 8'h58;
  localparam logic [7:0] OFS_PU_DIS = 8'h60;
  localparam logic [7:0] OFS_PU_EN = 8'h64;
  localparam logic [7:0] OFS_PU_ST = 8'h68;
  localparam logic [7:0] OFS_PA_SEL = 8'h70;
  localparam logic [7:0] OFS_PB_SEL = 8'h74;
  localparam logic [7:0] OFS_PAB_ST = 8'h78;
  localparam logic [7:0] OFS_DW_EN = 8'hA0;
  localparam logic [7:0] OFS_DW_DIS = 8'hA4;
  localparam logic [7:0] OFS_DW_ST = 8'hA8;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_ONES = 32'hFFFF_FFFF;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gpc_bus_req_t;

  typedef struct packed {
    logic [31:0] own;
    logic [31:0] drive;
    logic [31:0] level;
    logic [31:0] open_drain;
    logic [31:0] pullup_off;
    logic [31:0] periph_b;
  } gpc_pad_cfg_t;
endpackage

// file: test/gpc_chk_assertions.sv
// Port checker for gpc_top.
// Assumes one clock domain with async high reset.
`timescale 1ns/1ps
`default_nettype none
module gpc_chk #(
  parameter logic [31:0] LINE_MASK = 32'hFFFF_FFFF,
  parameter logic [31:0] MUX_MASK = 32'hFFFF_FFFF
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [gpc_pkg::AW-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [31:0] i_pin,
  input wire logic [31:0] o_periph_in,
  input wire gpc_pkg::gpc_pad_cfg_t o_pad_cfg,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic rd_flg;
  logic ok;
  assign rd_flg = i_rd && i_addr == gpc_pkg::OFS_CHG_FLAGS;
  assign ok = i_clk_en && i_pin == o_periph_in;
  a_periph_raw: assert property (o_periph_in == i_pin) else $error("periph input not raw");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata without read");
  a_unimpl_zero: assert property ((o_rdata & ~LINE_MASK) == 32'h0) else $error("unimplemented bit set");
  a_own_fixed: assert property ((o_pad_cfg.own | MUX_MASK | ~LINE_MASK) == 32'hFFFF_FFFF)
    else $error("unmuxed line not owned");
  a_cfg_hold: assert property (!$past(i_wr) |-> $stable(o_pad_cfg)) else $error("cfg moved without write");
  a_ab_clear: assert property (i_wr && i_addr == gpc_pkg::OFS_PA_SEL |=>
    (o_pad_cfg.periph_b & $past(i_wdata)) == 32'h0) else $error("A select kept B");
  a_ab_set: assert property (i_wr && i_addr == gpc_pkg::OFS_PB_SEL |=>
    (~o_pad_cfg.periph_b & $past(i_wdata) & LINE_MASK) == 32'h0) else $error("B select missed");
  a_pu_off: assert property (i_wr && i_addr == gpc_pkg::OFS_PU_DIS |=>
    (~o_pad_cfg.pullup_off & $past(i_wdata) & LINE_MASK) == 32'h0) else $error("pullup not off");
  // Quiet pins before and after the read, so no fresh change can relight it
  a_irq_clear: assert property ((ok && $stable(i_pin)) [*4] ##0 rd_flg ##1 (ok && $stable(i_pin)) [*2] |=> !o_irq)
    else $error("irq after flags read");
  c_flags: cover property (rd_flg ##1 o_rdata != 32'h0);
  c_irq: cover property ($rose(o_irq));
  c_dw: cover property (i_wr && i_addr == gpc_pkg::OFS_OUT_LVL);
endmodule
bind gpc_top gpc_chk #(.LINE_MASK(LINE_MASK), .MUX_MASK(MUX_MASK)) gpc_chk_inst (.*);
`default_nettype wire

// file: test/gpc_pin_model.sv
// Pin side model: levels plus timed pulses.
// Assumes requests change on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_model (
  input wire logic i_clk,
  input wire logic [31:0] i_lvl,
  input wire logic [31:0] i_flip,
  input wire logic [7:0] i_flip_ns,
  output logic [31:0] o_pin
);
  initial o_pin = 32'h0;
  // Pulse may span an edge, so the next edge is skipped
  always @(posedge i_clk) begin
    #3 o_pin = i_lvl ^ i_flip;
    if (i_flip != 32'h0) begin
      #(i_flip_ns) o_pin = i_lvl;
    end
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for gpc_top.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [31:0] LM = 32'h7FFF_FFFF;
  localparam logic [31:0] MM = 32'h0FFF_FFFF;
  logic clk = 1'h0, rst = 1'h1, en = 1'h1, wr = 1'h0, rd = 1'h0, irq;
  logic [7:0] addr = 8'h00, fns = 8'h05;
  logic [31:0] wd = 32'h0, lvl = 32'h0, flip = 32'h0, seen = 32'h0, p, m, s, c, rdata, pin, pin_in;
  gpc_pkg::gpc_pad_cfg_t cfg;
  logic [7:0] zro [12] = '{8'h18, 8'h28, 8'h38, 8'h3C, 8'h48, 8'h4C, 8'h58, 8'h68, 8'h78, 8'hA8, 8'h0C, 8'h00};
  logic [23:0] trio [9] = '{24'h000408, 24'h101418, 24'h202428, 24'h303438, 24'h404448, 24'h505458,
    24'h606468, 24'h747078, 24'hA0A4A8};
  int errors = 0, n_tests = 0;
  initial forever #12.5 clk = ~clk;
  gpc_pin_model gpc_pin_model_inst (.i_clk(clk), .i_lvl(lvl), .i_flip(flip), .i_flip_ns(fns), .o_pin(pin));
  gpc_top #(.LINE_MASK(LM), .MUX_MASK(MM)) gpc_top_inst (.i_clk(clk), .i_sys_rst(rst), .i_clk_en(en),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pin(pin), .o_periph_in(pin_in),
    .o_pad_cfg(cfg), .o_irq(irq));
  task automatic report_and_stop;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    #1;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'h0, a, 32'h0);
    cmp(what, exp, rdata);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(1635));
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    chk(8'h08, LM, "own_rst");
    foreach (zro[i]) chk(zro[i], 32'h0, "rst_zero");
    $display("done: reset values");
    foreach (trio[i]) begin
      s = $urandom();
      c = $urandom();
      bus(1'h1, trio[i][15:8], 32'hFFFF_FFFF);
      bus(1'h1, trio[i][23:16], s);
      bus(1'h1, trio[i][15:8], c);
      bus(1'h1, trio[i][7:0], 32'hFFFF_FFFF);
      chk(trio[i][7:0], ((s & ~c) | (trio[i][7:0] == 8'h08 ? ~MM : 32'h0)) & LM, "set_clr");
    end
    $display("done: set and clear");
    m = $urandom();
    bus(1'h1, 8'hA0, m);
    bus(1'h1, 8'h34, 32'hFFFF_FFFF);
    bus(1'h1, 8'h38, ~s);
    chk(8'h38, ~s & m & LM, "direct_write");
    $display("done: direct write");
    bus(1'h1, 8'h24, 32'hFFFF_FFFF);
    bus(1'h1, 8'h44, 32'hFFFF_FFFF);
    bus(1'h1, 8'h40, m);
    bus(1'h0, 8'h4C, 32'h0);
    repeat (8) begin
      p = $urandom();
      @(posedge clk);
      lvl <= p;
      repeat (4) @(posedge clk);
      #1 cmp("irq", {31'h0, |((p ^ seen) & m & LM)}, {31'h0, irq});
      chk(8'h3C, p & LM, "pin_level");
      chk(8'h4C, (p ^ seen) & LM, "flags");
      repeat (3) @(posedge clk);
      #1 cmp("irq_clr", 32'h0, {31'h0, irq});
      seen = p;
    end
    @(posedge clk);
    en <= 1'h0;
    lvl <= ~seen;
    repeat (4) @(posedge clk);
    chk(8'h3C, seen & LM, "frozen");
    chk(8'h4C, 32'h0, "no_detect");
    @(posedge clk);
    lvl <= seen;
    repeat (3) @(posedge clk);
    en <= 1'h1;
    $display("done: pins and flags");
    bus(1'h1, 8'h20, 32'hFFFF_FFFF);
    for (int k = 0; k < 2; k++) begin
      p = $urandom();
      @(posedge clk);
      fns <= k ? 8'h19 : 8'h05;
      flip <= p;
      @(posedge clk);
      flip <= 32'h0;
      repeat (6) @(posedge clk);
      chk(8'h4C, (k ? p : 32'h0) & LM, "filter");
    end
    $display("done: glitch filter");
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    chk(8'h08, LM, "own_rerst");
    $display("done: second reset");
    report_and_stop();
  end
endmodule
`default_nettype wire
